// file: include/pgfp_params.svh
// Purpose: Constants for the phase and ground fault protection supervisor.
// Assumes: 40 MHz clock.
// Notes:   Times are given in their own unit and converted to cycles here.
`ifndef PGFP_PARAMS_SVH
`define PGFP_PARAMS_SVH

`define PGFP_CLK_HZ            40000000
`define PGFP_IN_LOSS_TIME_MS   1000
`define PGFP_GND_CHECK_TIME_MS 20
`define PGFP_IN_LOSS_CYCLES    ((`PGFP_CLK_HZ / 1000) * `PGFP_IN_LOSS_TIME_MS)
`define PGFP_GND_CHECK_CYCLES  ((`PGFP_CLK_HZ / 1000) * `PGFP_GND_CHECK_TIME_MS)
`define PGFP_OUT_LOSS_EN_RST   1'h1
`define PGFP_IN_LOSS_EN_RST    1'h1
`define PGFP_GND_CHECK_EN_RST  1'h0
`define PGFP_CNT_W             26

`endif

// file: include/pgfp_pkg.sv
// Purpose: Types for the phase and ground fault protection supervisor.
// Assumes: Nothing beyond the parameter header.
// Notes:   Fault codes are one-hot free; zero means no fault.
package pgfp_pkg;

	typedef enum logic [1:0] {
		FC_NONE,
		FC_OUT_LOSS,
		FC_IN_LOSS,
		FC_GROUND
	} pgfp_fault_t;

	typedef struct packed {
		logic out_loss_en;
		logic in_loss_en;
		logic gnd_check_en;
	} pgfp_settings_t;

	typedef struct packed {
		logic [2:0] out_phase_missing;
		logic       in_phase_missing;
		logic       regenerating;
		logic       earth_fault;
	} pgfp_sense_t;

endpackage : pgfp_pkg

// file: rtl/pgfp_top.sv
// Purpose: Protection supervisor for phase loss and earth fault at start.
// Assumes: Sense inputs are synchronous; settings come from a parameter store.
// Notes:   Trips latch until reset or retry_clear.
`timescale 1ns/100ps
`include "pgfp_params.svh"

module pgfp_top (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// Settings store
	input  wire logic                   settings_we,
	input  wire pgfp_pkg::pgfp_settings_t settings_wdata,
	input  wire logic                   extended_display_select,
	// Run control
	input  wire logic                   start_cmd,
	input  wire logic                   retry_clear,
	// Sensing from the power stage
	input  wire pgfp_pkg::pgfp_sense_t  sense,
	// Results
	output logic                        drive_enable,
	output logic                        trip,
	output pgfp_pkg::pgfp_fault_t       fault_code,
	output pgfp_pkg::pgfp_settings_t    settings
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHECK,
		ST_RUN,
		ST_TRIP
	} pgfp_state_t;

	pgfp_state_t              state_q, state_d;
	pgfp_pkg::pgfp_settings_t set_q, set_d;
	pgfp_pkg::pgfp_fault_t    code_q, code_d;
	logic [`PGFP_CNT_W-1:0]   loss_cnt_q, loss_cnt_d;
	logic [`PGFP_CNT_W-1:0]   gnd_cnt_q, gnd_cnt_d;
	logic                     start_q;
	logic                     start_edge;
	logic                     out_loss_hit;
	logic                     in_loss_seen;
	logic                     in_loss_hit;
	logic                     drive_d;
	logic                     drive_q;
	logic                     trip_q;
	logic                     trip_d;

	localparam logic [`PGFP_CNT_W-1:0] IN_LOSS_LAST = `PGFP_CNT_W'(`PGFP_IN_LOSS_CYCLES - 1);
	localparam logic [`PGFP_CNT_W-1:0] GND_LAST     = `PGFP_CNT_W'(`PGFP_GND_CHECK_CYCLES - 1);

	assign start_edge = start_cmd & ~start_q;

	// Settings only change while the extended display select is 0; other writes are dropped.
	always_comb begin
		set_d = set_q;
		if (settings_we && !extended_display_select) begin
			set_d = settings_wdata;
		end
	end

	// Phase loss detection rests on the bus-voltage-derived flags from the power stage.
	always_comb begin
		out_loss_hit = set_q.out_loss_en && (|sense.out_phase_missing) && !sense.regenerating;
		in_loss_seen = set_q.in_loss_en && sense.in_phase_missing && !sense.regenerating;
		in_loss_hit  = in_loss_seen && (loss_cnt_q == IN_LOSS_LAST);
	end

	// Any break in the loss flag restarts the one second window.
	always_comb begin
		loss_cnt_d = '0;
		if (in_loss_seen && state_q == ST_RUN && loss_cnt_q != IN_LOSS_LAST) begin
			loss_cnt_d = loss_cnt_q + `PGFP_CNT_W'(1);
		end
	end

	always_comb begin
		state_d   = state_q;
		code_d    = code_q;
		gnd_cnt_d = '0;
		drive_d   = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (start_edge) begin
					if (set_q.gnd_check_en) begin
						state_d = ST_CHECK;
					end else begin
						state_d = ST_RUN;
						drive_d = 1'b1;
					end
				end
			end
			ST_CHECK: begin
				// Output stays off for the whole check window.
				gnd_cnt_d = gnd_cnt_q + `PGFP_CNT_W'(1);
				if (sense.earth_fault) begin
					state_d = ST_TRIP;
					code_d  = pgfp_pkg::FC_GROUND;
				end else if (gnd_cnt_q == GND_LAST) begin
					state_d = ST_RUN;
					drive_d = 1'b1;
				end
			end
			ST_RUN: begin
				// Earth fault is not looked at here, only at start.
				drive_d = 1'b1;
				if (out_loss_hit) begin
					state_d = ST_TRIP;
					code_d  = pgfp_pkg::FC_OUT_LOSS;
					drive_d = 1'b0;
				end else if (in_loss_hit) begin
					state_d = ST_TRIP;
					code_d  = pgfp_pkg::FC_IN_LOSS;
					drive_d = 1'b0;
				end else if (!start_cmd) begin
					state_d = ST_IDLE;
					drive_d = 1'b0;
				end
			end
			ST_TRIP: begin
				if (retry_clear) begin
					state_d = ST_IDLE;
					code_d  = pgfp_pkg::FC_NONE;
				end
			end
		endcase
		// The trip flag is a register of its own so the output is never a state decode.
		trip_d = (state_d == ST_TRIP);
	end

	// Settings survive a trip; only reset brings back the defaults.
	always_ff @(posedge clk) begin
		if (reset) begin
			set_q <= '{out_loss_en: `PGFP_OUT_LOSS_EN_RST, in_loss_en: `PGFP_IN_LOSS_EN_RST,
			           gnd_check_en: `PGFP_GND_CHECK_EN_RST};
		end else begin
			set_q <= set_d;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			loss_cnt_q <= '0;
		end else begin
			loss_cnt_q <= loss_cnt_d;
		end
	end

	// The edge detector idles low like the pin, so no false start follows reset.
	always_ff @(posedge clk) begin
		if (reset) begin
			start_q <= 1'h0;
		end else begin
			start_q <= start_cmd;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q   <= ST_IDLE;
			code_q    <= pgfp_pkg::FC_NONE;
			gnd_cnt_q <= '0;
			drive_q   <= 1'h0;
			trip_q    <= 1'h0;
		end else begin
			state_q   <= state_d;
			code_q    <= code_d;
			gnd_cnt_q <= gnd_cnt_d;
			drive_q   <= drive_d;
			trip_q    <= trip_d;
		end
	end

	// Every output is a register so downstream logic never sees decode glitches.
	assign drive_enable = drive_q;
	assign trip         = trip_q;
	assign fault_code   = code_q;
	assign settings     = set_q;

	chk_out_loss_off: assert property (@(posedge clk) disable iff (reset)
		!set_q.out_loss_en |-> code_d != pgfp_pkg::FC_OUT_LOSS || code_q == pgfp_pkg::FC_OUT_LOSS)
		else $error("Output loss fault raised while disabled.");

	chk_out_loss_trip: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_RUN && out_loss_hit) |=> (trip && fault_code == pgfp_pkg::FC_OUT_LOSS))
		else $error("Output loss did not trip.");

	chk_in_loss_wait: assert property (@(posedge clk) disable iff (reset)
		$rose(code_q == pgfp_pkg::FC_IN_LOSS) |-> $past(loss_cnt_q) == IN_LOSS_LAST)
		else $error("Input loss tripped before its window.");

	chk_in_loss_off: assert property (@(posedge clk) disable iff (reset)
		!set_q.in_loss_en |=> loss_cnt_q == '0)
		else $error("Input loss counted while disabled.");

	chk_regen_mask: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_RUN && sense.regenerating) |=> state_q != ST_TRIP)
		else $error("Phase loss reported during regeneration.");

	sequence s_check_start;
		state_q == ST_IDLE && start_edge && set_q.gnd_check_en;
	endsequence

	chk_check_hold: assert property (@(posedge clk) disable iff (reset)
		s_check_start |=> !drive_enable [*8])
		else $error("Output driven during ground check.");

	chk_gnd_trip: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_CHECK && sense.earth_fault) |=> (trip && fault_code == pgfp_pkg::FC_GROUND && !drive_enable))
		else $error("Ground fault at start did not trip.");

	chk_run_no_gnd: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_RUN && sense.earth_fault && !out_loss_hit && !in_loss_hit) |=> fault_code != pgfp_pkg::FC_GROUND)
		else $error("Ground fault tripped while running.");

	chk_trip_latch: assert property (@(posedge clk) disable iff (reset)
		(trip && !retry_clear) |=> (trip && $stable(fault_code) && !drive_enable))
		else $error("Trip did not hold.");

	// Settings bookkeeping: a refused write must leave every bit as it was.
	chk_settings_lock: assert property (@(posedge clk) disable iff (reset)
		(settings_we && extended_display_select) |=> $stable(settings))
		else $error("Settings changed while writes were locked.");

	chk_settings_take: assert property (@(posedge clk) disable iff (reset)
		(settings_we && !extended_display_select) |=> settings == $past(settings_wdata))
		else $error("Accepted settings write did not land.");

	// Reset is checked without the disable clause, since reset itself is the cause here.
	chk_reset_defaults: assert property (@(posedge clk)
		reset |=> (settings.out_loss_en == `PGFP_OUT_LOSS_EN_RST && settings.in_loss_en == `PGFP_IN_LOSS_EN_RST
			&& settings.gnd_check_en == `PGFP_GND_CHECK_EN_RST && !trip && !drive_enable
			&& fault_code == pgfp_pkg::FC_NONE))
		else $error("Outputs or settings wrong after reset.");

	chk_start_direct: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_IDLE && start_edge && !set_q.gnd_check_en) |=> (drive_enable && !trip))
		else $error("Start without ground check did not drive.");

	// The check window is long, so the counter is checked step by step as well as at its end.
	sequence s_check_counting;
		state_q == ST_CHECK && !sense.earth_fault && gnd_cnt_q != GND_LAST;
	endsequence

	chk_check_quiet: assert property (@(posedge clk) disable iff (reset)
		s_check_counting |=> !drive_enable)
		else $error("Output driven before the check window ended.");

	chk_check_count: assert property (@(posedge clk) disable iff (reset)
		s_check_counting |=> gnd_cnt_q == $past(gnd_cnt_q) + `PGFP_CNT_W'(1))
		else $error("Ground check counter skipped.");

	chk_check_end: assert property (@(posedge clk) disable iff (reset)
		($rose(drive_enable) && $past(state_q) == ST_CHECK) |-> $past(gnd_cnt_q) == GND_LAST)
		else $error("Output released before the full check window.");

	chk_in_loss_count: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_RUN && in_loss_seen && loss_cnt_q != IN_LOSS_LAST)
		|=> loss_cnt_q == $past(loss_cnt_q) + `PGFP_CNT_W'(1))
		else $error("Input loss window did not advance.");

	chk_in_loss_break: assert property (@(posedge clk) disable iff (reset)
		!in_loss_seen |=> loss_cnt_q == '0)
		else $error("Input loss window survived a break.");

	chk_in_loss_trip: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_RUN && in_loss_hit && !out_loss_hit) |=> (trip && fault_code == pgfp_pkg::FC_IN_LOSS))
		else $error("Input loss did not trip at the end of its window.");

	sequence s_trip_retry;
		trip && retry_clear;
	endsequence

	chk_retry_clear: assert property (@(posedge clk) disable iff (reset)
		s_trip_retry |=> (!trip && fault_code == pgfp_pkg::FC_NONE && !drive_enable))
		else $error("Retry did not clear the trip.");

	chk_trip_code: assert property (@(posedge clk) disable iff (reset)
		trip |-> fault_code != pgfp_pkg::FC_NONE)
		else $error("Trip without a fault code.");

	chk_trip_no_start: assert property (@(posedge clk) disable iff (reset)
		(trip && start_cmd) |=> !drive_enable)
		else $error("Start command drove the output during a trip.");

	// A single missing phase is enough; the check repeats for each output phase.
	for (genvar p = 0; p < 3; p++) begin : g_phase
		chk_phase_trip: assert property (@(posedge clk) disable iff (reset)
			(state_q == ST_RUN && set_q.out_loss_en && sense.out_phase_missing[p] && !sense.regenerating)
			|=> (trip && fault_code == pgfp_pkg::FC_OUT_LOSS))
			else $error("A single missing output phase did not trip.");
	end

endmodule : pgfp_top

// file: dv/pgfp_plant.sv
// Purpose: Supply and motor load as seen through the power stage.
// Assumes: The bench requests each condition as a level.
// Notes:   Sense lines lag the request by one clock, as a sampled stage would.
`timescale 1ns/100ps
module pgfp_plant (
	// Clock
	input  wire logic                  clk,
	// Requested conditions
	input  wire pgfp_pkg::pgfp_sense_t want,
	// Sensed levels
	output pgfp_pkg::pgfp_sense_t      sense
);
	always_ff @(posedge clk) begin
		sense <= want;
	end
endmodule : pgfp_plant

// file: dv/phase_and_ground_fault_protection_test.sv
// Purpose: Self-checking bench for the protection supervisor.
// Assumes: Status is packed as drive_enable, trip, fault_code.
// Notes:   The 1s and 20ms figures are too long to run out; only their early phase is seen.
`timescale 1ns/100ps
module phase_and_ground_fault_protection_test;
	logic                     clk = 1'h0;
	logic                     reset = 1'h1;
	logic                     settings_we = 1'h0;
	logic                     extended_display_select = 1'h0;
	logic                     start_cmd = 1'h0;
	logic                     retry_clear = 1'h0;
	pgfp_pkg::pgfp_settings_t wdata = 3'h0;
	pgfp_pkg::pgfp_sense_t    want = 6'h00;
	pgfp_pkg::pgfp_sense_t    sense;
	pgfp_pkg::pgfp_fault_t    fault_code;
	pgfp_pkg::pgfp_settings_t settings;
	logic                     drive_enable;
	logic                     trip;
	int                       fails = 0;
	int                       n_checks = 0;
	always #12.5 clk = ~clk;
	pgfp_plant u_plant (.clk(clk), .want(want), .sense(sense));
	pgfp_top u_dut (.clk(clk), .reset(reset), .settings_we(settings_we), .settings_wdata(wdata),
		.extended_display_select(extended_display_select), .start_cmd(start_cmd),
		.retry_clear(retry_clear), .sense(sense), .drive_enable(drive_enable), .trip(trip),
		.fault_code(fault_code), .settings(settings));
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic status(input int n, input logic [3:0] exp);
		repeat (n) @(posedge clk);
		#1 check({drive_enable, trip, fault_code}, exp);
	endtask : status
	task automatic setup(input logic [2:0] s, input logic [2:0] exp);
		@(posedge clk);
		wdata <= s;
		settings_we <= 1'h1;
		@(posedge clk);
		settings_we <= 1'h0;
		repeat (2) @(posedge clk);
		check({1'h0, settings}, {1'h0, exp});
	endtask : setup
	task automatic go;
		@(posedge clk);
		start_cmd <= 1'h1;
	endtask : go
	task automatic clear(input string name);
		@(posedge clk);
		start_cmd <= 1'h0;
		want <= 6'h00;
		retry_clear <= 1'h1;
		@(posedge clk);
		retry_clear <= 1'h0;
		status(3, 4'h0);
		$display("test %s done", name);
	endtask : clear
	task automatic sc_defaults;
		status(1, 4'h0);
		check({1'h0, settings}, 4'h6);
		@(posedge clk);
		extended_display_select <= 1'h1;
		setup(3'h0, 3'h6);
		@(posedge clk);
		extended_display_select <= 1'h0;
		$display("test defaults done");
	endtask : sc_defaults
	task automatic sc_output_loss;
		go();
		status(3, 4'h8);
		@(posedge clk);
		want.earth_fault <= 1'h1;
		status(5, 4'h8);
		// One output phase and the supply phase missing while regenerating: both checks stay quiet.
		@(posedge clk);
		want <= 6'h16;
		status(5, 4'h8);
		@(posedge clk);
		want.regenerating <= 1'h0;
		status(3, 4'h5);
		@(posedge clk);
		want <= 6'h00;
		status(5, 4'h5);
		clear("output_loss");
	endtask : sc_output_loss
	task automatic sc_disabled;
		setup(3'h0, 3'h0);
		go();
		@(posedge clk);
		want <= 6'h3C;
		status(60, 4'h8);
		clear("disabled");
	endtask : sc_disabled
	task automatic sc_input_loss;
		setup(3'h2, 3'h2);
		go();
		@(posedge clk);
		want.in_phase_missing <= 1'h1;
		status(2000, 4'h8);
		clear("input_loss");
	endtask : sc_input_loss
	task automatic sc_reset_again;
		setup(3'h4, 3'h4);
		go();
		status(2, 4'h8);
		@(posedge clk);
		reset <= 1'h1;
		start_cmd <= 1'h0;
		@(posedge clk);
		reset <= 1'h0;
		status(1, 4'h0);
		check({1'h0, settings}, 4'h6);
		$display("test reset done");
	endtask : sc_reset_again
	task automatic sc_ground;
		int i;
		setup(3'h7, 3'h7);
		go();
		status(1000, 4'h0);
		@(posedge clk);
		want.earth_fault <= 1'h1;
		for (i = 0; i < 50 && trip !== 1'h1; i++) @(posedge clk);
		if (trip !== 1'h1) begin
			check({3'h0, trip}, 4'h1);
			return;
		end
		status(2, 4'h7);
		clear("ground");
	endtask : sc_ground
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'h0;
		sc_defaults();
		sc_output_loss();
		sc_disabled();
		sc_input_loss();
		sc_reset_again();
		sc_ground();
		summarize();
	end
endmodule : phase_and_ground_fault_protection_test
